// ===== cell_bus_consts.svh
// Offsets, field positions, reset values and counts of the cell bus port
`ifndef CELL_BUS_CONSTS_SVH
`define CELL_BUS_CONSTS_SVH
`define OFS_TX_MODE  8'h00
`define OFS_RX_MODE  8'h04
`define OFS_TAG      8'h08
`define OFS_THRESH   8'h0C
`define OFS_STATUS   8'h10
`define OFS_FLAGS    8'h14
`define MODE_RESET   4'h0
`define TAG_RESET    32'h0000_0000
`define THRESH_RESET 8'h00
`define TX_PINS_IDLE 37'h04_0000_0000
`define ST_TX_PAR    0
`define ST_TX_OVF    4
`define ST_RX_OVF    8
`define CELL_WORDS   9'h00E
`define FIFO_WORDS   9'h100
`define HEC_POLY     8'h07
`define HEC_COSET    8'h55
`define LEN_BASE     4'hD
`endif

// ===== cell_bus_master_model.sv
// Far-side cell bus master: pushes transmit cells and pulls receive cells
`timescale 1ns/1ps
`default_nettype none
module cell_bus_master_model (
  // Link clocks
  input  wire logic        tx_clk,
  input  wire logic        rx_clk,
  // Transmit pins
  output logic      [31:0] tx_word,
  output logic             tx_start,
  output logic             tx_en_n,
  output logic             tx_par,
  output logic      [1:0]  tx_sel,
  // Receive pins
  output logic             rx_en_n,
  output logic      [1:0]  rx_sel,
  input  wire logic [31:0] rx_word,
  input  wire logic        rx_start,
  input  wire logic        rx_par
);
  logic [33:0] got [$];
  int          lag;
  // Idle levels
  initial begin
    tx_word = 32'h0;
    tx_start = 1'b0;
    tx_en_n = 1'b1;
    tx_par = 1'b0;
    tx_sel = 2'h0;
    rx_en_n = 1'b1;
    rx_sel = 2'h0;
  end
  // Sends n words; pins change just after each rising link edge
  task automatic send(input logic [1:0] p, input int n, input logic [31:0] b, input logic bad);
    // port chosen the cycle before enable
    @(posedge tx_clk) tx_sel <= p;
    for (int i = 0; i < n; i++) begin
      @(posedge tx_clk);
      // whole cell, start flag on first word only
      tx_en_n <= 1'b0;
      tx_start <= (i == 0);
      tx_word <= b + i;
      tx_par <= ^(b + i) ^ bad;
    end
    @(posedge tx_clk);
    tx_en_n <= 1'b1;
    tx_start <= 1'b0;
    tx_word <= ~tx_word;
    tx_sel <= ~p;
  endtask
  // Pulls one cell, recording parity, start and word per link cycle
  task automatic recv(input logic [1:0] p, input int n);
    got.delete();
    // port chosen the cycle before enable
    @(posedge rx_clk) rx_sel <= p;
    @(posedge rx_clk) rx_en_n <= 1'b0;
    @(posedge rx_clk) rx_en_n <= 1'b1;
    // link cycles from enable sample to start flag
    for (lag = 0; lag < 8 && rx_start !== 1'b1; lag++) @(posedge rx_clk);
    for (int i = 0; i < n; i++) begin
      got.push_back({rx_par, rx_start, rx_word});
      @(posedge rx_clk);
    end
    rx_sel <= ~p;
  endtask
endmodule
`default_nettype wire

// ===== cell_bus_pkg.sv
// Types shared by the cell bus port block
package cell_bus_pkg;
  typedef struct packed {
    logic odd;
    logic direct;
    logic tag;
    logic user_defined_bytes;
  } mode_t;
  typedef struct packed {
    logic        valid;
    logic [1:0]  port;
    logic [31:0] word;
  } line_word_t;
  typedef struct packed {
    logic        par;
    logic        soc;
    logic        en_n;
    logic [1:0]  sel;
    logic [31:0] word;
  } tx_pins_t;
  typedef enum logic [0:0] {rx_idle, rx_send} rx_state_t;
endpackage

// ===== cell_bus_port.sv
// Four-port 32-bit cell bus slave with per-port transmit and receive FIFOs
// Operation
// RULE1: Sample transmit pins on transmit clock, receive pins on receive clock.
// RULE2: Far side drives 32-bit transmit words, bit 31 most significant.
// RULE3: Far side raises transmit start only in a cell's first cycle.
// RULE4: Transmit enable starts transfer; port comes from address before enable.
// RULE5: Check transmit parity bit over all 32 data bits.
// RULE6: Transmit space flags: flag 0 when polling, one per port direct.
// RULE7: Transmit port address values 0..3 select ports 0..3.
// RULE8: Drive 32-bit receive words, bit 31 most significant.
// RULE9: Receive start marks only the first cycle of each cell.
// RULE10: Receive enable starts transfer; port from address before enable.
// RULE11: Generate receive parity over the 32 output data bits.
// RULE12: Receive cell flags show a whole cell waits; flag 0 when polling.
// RULE13: Receive port address values 0..3 select ports 0..3.
// RULE14: 1K-byte FIFOs per port, overflow detect, per-port space threshold.
// RULE15: Without user bytes take 13 words and insert computed HEC.
// RULE16: With user bytes take 14 words, overwrite H5 with computed HEC.
// RULE17: With user bytes on receive, second word carries HEC and zeros.
// RULE18: Without user bytes on receive, drop HEC and send 13 words.
// RULE19: User-byte and tag options set separately per direction.
// RULE20: Transmit tag mode discards the start word as tag.
// RULE21: Receive tag mode sends programmed tag word with start flag first.
// RULE22: Without tag, start flag goes with the first cell word.
// RULE23: Polling answers on flag 0 two cycles after the address.
// RULE24: Receive data begins two cycles after enable falls.
// RULE25: Direct transmit flag holds until edge after next start on port.
// RULE26: Parity sense selectable; parity error and overflow readable status.
// RULE27: Receive outputs rest at a fixed idle level between cells.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cell_bus_consts.svh"
module cell_bus_port (
  // System
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic [7:0]               paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Transmit link
  input  wire logic                     tx_iface_clock,
  input  wire logic [31:0]              tx_cell_word,
  input  wire logic                     tx_cell_start,
  input  wire logic                     tx_enable_n,
  input  wire logic                     tx_word_parity,
  input  wire logic [1:0]               tx_port_sel,
  output logic      [3:0]               tx_space_avail,
  // Receive link
  input  wire logic                     rx_iface_clock,
  input  wire logic                     rx_enable_n,
  input  wire logic [1:0]               rx_port_sel,
  output logic      [31:0]              rx_cell_word,
  output logic                          rx_cell_start,
  output logic                          rx_word_parity,
  output logic      [3:0]               rx_cell_avail,
  // Line side
  input  wire logic [1:0]               tx_drain_port,
  input  wire logic                     tx_drain_pop,
  output cell_bus_pkg::line_word_t      tx_drain,
  output logic      [3:0]               tx_cell_ready,
  input  wire cell_bus_pkg::line_word_t rx_fill
);

  // ==========================================================
  // Registers
  cell_bus_pkg::mode_t  tx_mode;
  cell_bus_pkg::mode_t  rx_mode;
  logic [31:0]          rx_tag_value;
  logic [7:0]           tx_fifo_threshold;
  logic [11:0]          status;
  logic [11:0]          st_set;
  logic                 ack;
  logic                 apb_hit;
  logic                 apb_wr;
  logic [31:0]          rd_mux;

  // Address decode and read mux
  always_comb begin
    apb_hit = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `OFS_TX_MODE: rd_mux = {28'h0000000, tx_mode};
      `OFS_RX_MODE: rd_mux = {28'h0000000, rx_mode};
      `OFS_TAG:     rd_mux = rx_tag_value;
      `OFS_THRESH:  rd_mux = {24'h000000, tx_fifo_threshold};
      `OFS_STATUS:  rd_mux = {20'h00000, status};
      `OFS_FLAGS:   rd_mux = {24'h000000, rx_cell_avail, tx_space_avail};
      default:      apb_hit = 1'b0;
    endcase
  end

  // One wait state, then answer
  assign pready  = psel & penable & ack;
  assign pslverr = pready & ~apb_hit;
  assign apb_wr  = pready & pwrite & apb_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack    <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ack <= psel & penable & ~ack;
      if (psel & penable & ~ack & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // RULE19 per-direction mode, tag, threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mode           <= `MODE_RESET;
      rx_mode           <= `MODE_RESET;
      rx_tag_value      <= `TAG_RESET;
      tx_fifo_threshold <= `THRESH_RESET;
    end else if (apb_wr) begin
      if (paddr == `OFS_TX_MODE) tx_mode <= pwdata[3:0];
      if (paddr == `OFS_RX_MODE) rx_mode <= pwdata[3:0];
      if (paddr == `OFS_TAG) rx_tag_value <= pwdata;
      if (paddr == `OFS_THRESH) tx_fifo_threshold <= pwdata[7:0];
    end
  end

  // RULE26 sticky status, set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status <= 12'h000;
    else if (apb_wr && paddr == `OFS_STATUS)
      status <= (status & ~pwdata[11:0]) | st_set;
    else
      status <= status | st_set;
  end

  // ==========================================================
  // Transmit side
  logic [2:0]              tclk_s;
  cell_bus_pkg::tx_pins_t  tin_s0, tin_s1, tin_s2;
  logic                    tx_edge;
  logic [31:0]             tx_mem [0:1023];
  logic [8:0]              tx_wr [4];
  logic [8:0]              tx_rd [4];
  logic [8:0]              tx_used [4];
  logic [3:0]              tx_cond;
  logic [3:0]              tx_av;
  logic [3:0]              soc_prev;
  logic [3:0]              tx_ovf_ev;
  logic [1:0]              tx_cur_port;
  logic [1:0]              tx_poll_q;
  logic                    tx_run;
  logic                    tx_drop;
  logic                    hec_pend;
  logic [3:0]              tx_idx;
  logic [31:0]             tx_hdr;
  logic                    tx_take;
  logic                    tx_cellw;
  logic [3:0]              tx_wi;
  logic [3:0]              tx_slot;
  logic                    tx_par_err;

  // HEC: CRC-8 over the four header bytes, plus coset
  function automatic logic [7:0] hec_of(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? `HEC_POLY : 8'h00);
    return c ^ `HEC_COSET;
  endfunction

  // RULE1 two-stage sync plus one age stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_s <= 3'h0;
      tin_s0 <= `TX_PINS_IDLE; // Enable at rest, so no false take
      tin_s1 <= `TX_PINS_IDLE;
      tin_s2 <= `TX_PINS_IDLE;
    end else begin
      tclk_s <= {tclk_s[1:0], tx_iface_clock};
      tin_s0 <= {tx_word_parity, tx_cell_start, tx_enable_n, tx_port_sel, tx_cell_word};
      tin_s1 <= tin_s0;
      tin_s2 <= tin_s1;
    end
  end

  // Data seen just before the link edge
  assign tx_edge  = tclk_s[1] & ~tclk_s[2];
  assign tx_take  = tx_edge & ~tin_s2.en_n & (tin_s2.soc | tx_run);
  // RULE20 tag word is not a cell word
  assign tx_cellw = tx_take & ~(tin_s2.soc & tx_mode.tag);
  assign tx_wi    = tin_s2.soc ? 4'h0 : tx_idx;
  // RULE15 RULE16 slot 1 always holds the computed HEC
  assign tx_slot  = (tx_mode.user_defined_bytes || tx_wi == 4'h0) ? tx_wi : tx_wi + 4'h1;
  // RULE5 RULE26 parity check with selectable sense
  assign tx_par_err = tx_take & (^{tin_s2.word, tin_s2.par} ^ tx_mode.odd);

  // Space and threshold per port
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      tx_used[p]       = tx_wr[p] - tx_rd[p];
      tx_cell_ready[p] = tx_used[p] >= `CELL_WORDS;
      // RULE14 free space against threshold plus cell in flight
      tx_cond[p] = (`FIFO_WORDS - tx_used[p]) >=
                   (9'(({7'h00, tx_fifo_threshold[2*p +: 2]} + 9'h001) * `CELL_WORDS)
                    + ((tx_run && tx_cur_port == 2'(p)) ? `CELL_WORDS : 9'h000));
      tx_ovf_ev[p] = tx_edge & ~tin_s2.en_n & tin_s2.soc & (tx_cur_port == 2'(p))
                     & ((`FIFO_WORDS - tx_used[p]) < `CELL_WORDS);
    end
  end

  // Cell assembly control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cur_port <= 2'h0;
      tx_run      <= 1'b0;
      tx_drop     <= 1'b0;
      tx_idx      <= 4'h0;
      hec_pend    <= 1'b0;
      tx_hdr      <= 32'h0000_0000;
    end else begin
      hec_pend <= 1'b0;
      if (tx_edge) begin
        // RULE4 RULE7 port latched while enable is high
        if (tin_s2.en_n)
          tx_cur_port <= tin_s2.sel;
        if (tx_take && tin_s2.soc) begin
          tx_run  <= 1'b1;
          tx_drop <= tx_ovf_ev[tx_cur_port];
          // RULE22 start word is cell word without tag
          tx_idx  <= tx_mode.tag ? 4'h0 : 4'h1;
        end else if (tx_take) begin
          tx_idx <= tx_idx + 4'h1;
        end
        if (tx_cellw && tx_wi == 4'h0)
          tx_hdr <= tin_s2.word;
        if (tx_cellw && tx_wi == (tx_mode.user_defined_bytes ? 4'hD : 4'hC)) begin
          tx_run   <= 1'b0;
          hec_pend <= ~tx_drop;
        end
      end
    end
  end

  // FIFO storage; HEC written one cycle after the last word
  always_ff @(posedge pclk) begin
    if (hec_pend)
      tx_mem[{tx_cur_port, tx_wr[tx_cur_port][7:0] + 8'h01}] <= {hec_of(tx_hdr), 24'h000000};
    else if (tx_cellw && !tx_drop && !(tx_mode.user_defined_bytes && tx_wi == 4'h1))
      tx_mem[{tx_cur_port, tx_wr[tx_cur_port][7:0] + {4'h0, tx_slot}}] <= tin_s2.word;
  end

  // Commit whole cells; drain one word per pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wr    <= '{default: 9'h000};
      tx_rd    <= '{default: 9'h000};
      tx_drain <= '0;
    end else begin
      if (hec_pend)
        tx_wr[tx_cur_port] <= tx_wr[tx_cur_port] + `CELL_WORDS;
      tx_drain.valid <= 1'b0;
      if (tx_drain_pop && tx_used[tx_drain_port] != 9'h000) begin
        tx_drain <= {1'b1, tx_drain_port,
                     tx_mem[{tx_drain_port, tx_rd[tx_drain_port][7:0]}]};
        tx_rd[tx_drain_port] <= tx_rd[tx_drain_port] + 9'h001;
      end
    end
  end

  // RULE6 RULE23 RULE25 transmit space flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_av          <= 4'h0;
      soc_prev       <= 4'h0;
      tx_poll_q      <= 2'h0;
      tx_space_avail <= 4'h0;
    end else if (tx_edge) begin
      tx_poll_q <= tin_s2.sel;
      tx_av     <= (tx_av & ~soc_prev) | tx_cond;
      for (int p = 0; p < 4; p++)
        soc_prev[p] <= ~tin_s2.en_n & tin_s2.soc & (tx_cur_port == 2'(p));
      tx_space_avail <= tx_mode.direct ? tx_av : {3'h0, tx_av[tx_poll_q]};
    end
  end

  // ==========================================================
  // Receive side
  logic [2:0]              rclk_s;
  logic [2:0]              rin_s0, rin_s1, rin_s2;
  logic                    rx_edge;
  logic [31:0]             rx_mem [0:1023];
  logic [8:0]              rx_wr [4];
  logic [8:0]              rx_rd [4];
  logic [3:0]              rx_eff;
  logic [3:0]              rx_ovf_ev;
  cell_bus_pkg::rx_state_t rx_state, next_state;
  logic [3:0]              rx_idx, next_idx, rx_last, j, slot;
  logic [1:0]              rx_port, next_port, rx_cur_port, rx_poll_q;
  logic [7:0]              rx_base, next_base;
  logic                    go, go_q, fin;
  logic [31:0]             next_word, mem_word;

  // RULE1 sync receive clock and controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rclk_s <= 3'h0;
      rin_s0 <= 3'h4;
      rin_s1 <= 3'h4;
      rin_s2 <= 3'h4;
    end else begin
      rclk_s <= {rclk_s[1:0], rx_iface_clock};
      rin_s0 <= {rx_enable_n, rx_port_sel};
      rin_s1 <= rin_s0;
      rin_s2 <= rin_s1;
    end
  end
  assign rx_edge = rclk_s[1] & ~rclk_s[2];

  // RULE12 RULE14 whole cells waiting, less the cell being sent
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      rx_eff[p] = (rx_wr[p] - rx_rd[p]
                   - ((rx_state == cell_bus_pkg::rx_send && rx_port == 2'(p))
                      ? `CELL_WORDS : 9'h000)) >= `CELL_WORDS;
      rx_ovf_ev[p] = rx_fill.valid && rx_fill.port == 2'(p)
                     && (rx_wr[p] - rx_rd[p]) == `FIFO_WORDS;
    end
  end

  // Line side fill; full FIFO drops the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rx_wr <= '{default: 9'h000};
    else if (rx_fill.valid && !rx_ovf_ev[rx_fill.port])
      rx_wr[rx_fill.port] <= rx_wr[rx_fill.port] + 9'h001;
  end
  always_ff @(posedge pclk) begin
    if (rx_fill.valid && !rx_ovf_ev[rx_fill.port])
      rx_mem[{rx_fill.port, rx_wr[rx_fill.port][7:0]}] <= rx_fill.word;
  end

  // RULE17 RULE18 RULE21 cell length and next word
  assign rx_last = `LEN_BASE + {3'h0, rx_mode.user_defined_bytes} + {3'h0, rx_mode.tag} - 4'h1;
  // RULE10 RULE24 start two link cycles after enable, back to back too
  assign go = ~rin_s2[2] & rx_eff[rx_cur_port] &
              ((rx_state == cell_bus_pkg::rx_idle && !go_q) ||
               (rx_state == cell_bus_pkg::rx_send && rx_idx == rx_last - 4'h1));

  always_comb begin
    next_state = rx_state;
    next_idx   = rx_idx;
    next_port  = rx_port;
    next_base  = rx_base;
    fin        = 1'b0;
    if (rx_state == cell_bus_pkg::rx_send && rx_idx != rx_last)
      next_idx = rx_idx + 4'h1;
    else begin
      fin        = rx_state == cell_bus_pkg::rx_send;
      next_state = go_q ? cell_bus_pkg::rx_send : cell_bus_pkg::rx_idle;
      if (go_q) begin
        next_idx  = 4'h0;
        next_port = rx_cur_port;
        next_base = rx_rd[rx_cur_port][7:0]
                    + ((fin && rx_port == rx_cur_port) ? 8'h0E : 8'h00);
      end
    end
    j        = next_idx - {3'h0, rx_mode.tag};
    slot     = (rx_mode.user_defined_bytes || j == 4'h0) ? j : j + 4'h1;
    mem_word = rx_mem[{next_port, next_base + {4'h0, slot}}];
    case (1'b1)
      next_state == cell_bus_pkg::rx_idle:   next_word = 32'h0000_0000;
      rx_mode.tag && next_idx == 4'h0:       next_word = rx_tag_value;
      slot == 4'h1:                          next_word = {mem_word[31:24], 24'h000000};
      default:                               next_word = mem_word;
    endcase
  end

  // RULE8 RULE9 RULE11 RULE22 RULE27 registered receive outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state       <= cell_bus_pkg::rx_idle;
      rx_idx         <= 4'h0;
      rx_port        <= 2'h0;
      rx_base        <= 8'h00;
      go_q           <= 1'b0;
      rx_cur_port    <= 2'h0;
      rx_rd          <= '{default: 9'h000};
      rx_cell_word   <= 32'h0000_0000;
      rx_cell_start  <= 1'b0;
      rx_word_parity <= 1'b0;
    end else if (rx_edge) begin
      // RULE13 port taken while enable is high
      if (rin_s2[2])
        rx_cur_port <= rin_s2[1:0];
      go_q     <= go;
      rx_state <= next_state;
      rx_idx   <= next_idx;
      rx_port  <= next_port;
      rx_base  <= next_base;
      if (fin)
        rx_rd[rx_port] <= rx_rd[rx_port] + `CELL_WORDS;
      rx_cell_word   <= next_word;
      rx_cell_start  <= next_state == cell_bus_pkg::rx_send && next_idx == 4'h0;
      rx_word_parity <= ^next_word ^ rx_mode.odd;
    end
  end

  // RULE12 RULE23 receive flags, poll answer two cycles on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_poll_q     <= 2'h0;
      rx_cell_avail <= 4'h0;
    end else if (rx_edge) begin
      rx_poll_q     <= rin_s2[1:0];
      rx_cell_avail <= rx_mode.direct ? rx_eff : {3'h0, rx_eff[rx_poll_q]};
    end
  end

  // RULE14 RULE26 status events
  assign st_set = {rx_ovf_ev, tx_ovf_ev, 3'h0, tx_par_err};

  // ==========================================================
  // Checks
  // RULE27 idle level
  rx_idle_level_a: assert property ( // RULE27
    @(posedge pclk) disable iff (!presetn)
    rx_state == cell_bus_pkg::rx_idle |-> rx_cell_word == 32'h0 && !rx_cell_start)
    else $error("receive outputs not idle");
  // RULE11 receive parity
  rx_parity_gen_a: assert property ( // RULE11
    @(posedge pclk) disable iff (!presetn)
    rx_edge && !apb_wr |=> rx_word_parity == (^rx_cell_word ^ rx_mode.odd))
    else $error("receive parity wrong");
  // RULE9 start only first cycle
  rx_start_first_a: assert property ( // RULE9
    @(posedge pclk) disable iff (!presetn)
    rx_cell_start |-> rx_idx == 4'h0 && rx_state == cell_bus_pkg::rx_send)
    else $error("receive start not on first word");
  // RULE21 tag word value
  rx_tag_word_a: assert property ( // RULE21
    @(posedge pclk) disable iff (!presetn)
    rx_edge && rx_mode.tag && next_state == cell_bus_pkg::rx_send && next_idx == 4'h0
    |=> rx_cell_start && rx_cell_word == $past(rx_tag_value))
    else $error("tag word missing");
  // RULE24 start follows pending enable
  rx_start_delay_a: assert property ( // RULE24
    @(posedge pclk) disable iff (!presetn)
    rx_edge && go_q && rx_state == cell_bus_pkg::rx_idle
    |=> rx_state == cell_bus_pkg::rx_send && rx_cell_start)
    else $error("receive cell did not start");
  // RULE6 polling uses flag 0 only
  tx_poll_flags_a: assert property ( // RULE6
    @(posedge pclk) disable iff (!presetn)
    !tx_mode.direct && tx_edge |=> tx_space_avail[3:1] == 3'h0)
    else $error("poll mode upper flags set");
  // RULE25 direct flag stays until after start
  tx_flag_hold_a: assert property ( // RULE25
    @(posedge pclk) disable iff (!presetn)
    tx_edge |=> (($past(tx_av) & ~$past(soc_prev) & ~tx_av) == 4'h0))
    else $error("space flag dropped early");
  // RULE26 parity error recorded
  tx_parity_flag_a: assert property ( // RULE26
    @(posedge pclk) disable iff (!presetn)
    tx_par_err |=> status[`ST_TX_PAR])
    else $error("parity error not recorded");
  // RULE12 polling uses flag 0 only
  rx_poll_flags_a: assert property ( // RULE12
    @(posedge pclk) disable iff (!presetn)
    rx_edge && !rx_mode.direct |=> rx_cell_avail[3:1] == 3'h0)
    else $error("poll mode upper receive flags set");

endmodule
`default_nettype wire

// ===== test_quad_port_cell_bus_phy_side.sv
// Self-checking bench of the four-port cell bus block
`timescale 1ns/1ps
`default_nettype none
module test_quad_port_cell_bus_phy_side;
  // ====
  // Stimulus and observed nets
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pop = 0;
  logic txck = 0, rxck = 0, pready, pslverr, tsoc, ten, tpar, ren, rsoc, rpar;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, tword, rword, r;
  logic [1:0]  tsel, rsel, dport = 2'h0;
  logic [3:0]  tav, rav, ready;
  logic [33:0] x;
  logic [31:0] dw [14];
  cell_bus_pkg::line_word_t drn, fill = '0;
  int errors = 0, comparisons = 0, cycles = 0;
  // Clocks: 125 MHz system, two 80 ns link clocks of unrelated phase
  initial forever #4 pclk = ~pclk;
  initial forever #40 txck = ~txck;
  initial begin #13; forever #40 rxck = ~rxck; end
  cell_bus_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_iface_clock(txck), .tx_cell_word(tword), .tx_cell_start(tsoc),
    .tx_enable_n(ten), .tx_word_parity(tpar), .tx_port_sel(tsel), .tx_space_avail(tav),
    .rx_iface_clock(rxck), .rx_enable_n(ren), .rx_port_sel(rsel), .rx_cell_word(rword),
    .rx_cell_start(rsoc), .rx_word_parity(rpar), .rx_cell_avail(rav),
    .tx_drain_port(dport), .tx_drain_pop(pop), .tx_drain(drn), .tx_cell_ready(ready),
    .rx_fill(fill));
  cell_bus_master_model link (.tx_clk(txck), .rx_clk(rxck), .tx_word(tword),
    .tx_start(tsoc), .tx_en_n(ten), .tx_par(tpar), .tx_sel(tsel), .rx_en_n(ren),
    .rx_sel(rsel), .rx_word(rword), .rx_start(rsoc), .rx_par(rpar));
  // ====
  // Tasks
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer: hold request until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata[30:0]} ^ {prdata[31], 31'h0};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] fw(input int i);
    return (i == 1) ? 32'h5A00_0000 : (i == 0) ? 32'h4000_0100 : 32'hD000_0000 + i;
  endfunction
  task automatic drain(input logic [1:0] p);
    for (int i = 0; i < 14; i++) begin
      @(posedge pclk);
      dport <= p;
      pop <= 1'b1;
      @(posedge pclk) pop <= 1'b0;
      while (drn.valid !== 1'b1) @(posedge pclk);
      dw[i] = drn.word;
    end
  endtask
  task automatic load(input logic [1:0] p);
    for (int i = 0; i < 14; i++) @(posedge pclk) fill <= {1'b1, p, fw(i)};
    @(posedge pclk) fill <= '0;
  endtask
  // ====
  // Timeout
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin errors++; print_verdict(); end
  end
  // ====
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(8'h00, 0, 0); check(r, 32'h0);
    check(tav, 32'h1);
    apb(8'h18, 0, 0); check(r, 32'h8000_0000);
    apb(8'h08, 1, 32'hA5C3_0F1E); apb(8'h08, 0, 0); check(r, 32'hA5C3_0F1E);
    link.send(2'h2, 13, 32'h1000_0000, 0);
    repeat (20) @(posedge pclk);
    check({31'h0, ready[2]}, 32'h1);
    drain(2'h2);
    check(dw[0], 32'h1000_0000); check(dw[1] & 32'hFFFFFF, 0);
    for (int i = 2; i < 14; i++) check(dw[i], 32'h1000_0000 + i - 1);
    apb(8'h10, 0, 0); check(r, 32'h0);
    link.send(2'h1, 13, 32'h2000_0000, 1);
    repeat (20) @(posedge pclk);
    apb(8'h10, 0, 0); check(r & 32'h1, 32'h1);
    apb(8'h10, 1, 32'h1); apb(8'h10, 0, 0); check(r & 32'h1, 32'h0);
    apb(8'h00, 1, 32'h3); link.send(2'h0, 15, 32'h3000_0000, 0);
    repeat (20) @(posedge pclk);
    drain(2'h0);
    check(dw[0], 32'h3000_0001);
    for (int i = 2; i < 14; i++) check(dw[i], 32'h3000_0001 + i);
    apb(8'h00, 1, 32'h4);
    repeat (30) @(posedge pclk);
    check(tav, 32'hF);
    load(2'h3); link.recv(2'h3, 13);
    check(link.lag, 32'h2);
    for (int k = 0; k < 13; k++) begin
      x = link.got[k];
      check(x[31:0], fw(k == 0 ? 0 : k + 1));
      check({31'h0, x[32]}, {31'h0, k == 0});
      check({31'h0, x[33]}, {31'h0, ^x[31:0]});
    end
    repeat (30) @(posedge pclk);
    check(rword, 32'h0);
    apb(8'h04, 1, 32'hB); load(2'h0);
    repeat (40) @(posedge pclk);
    check(rav, 32'h1);
    link.recv(2'h0, 15);
    check(link.lag, 32'h2);
    for (int k = 0; k < 15; k++) begin
      x = link.got[k];
      check(x[31:0], k == 0 ? 32'hA5C3_0F1E : fw(k - 1));
      check({31'h0, x[32]}, {31'h0, k == 0});
      check({31'h0, x[33]}, {31'h0, ~^x[31:0]});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
